/* design/tcwpi_top.sv */
// Serial control word decoder and pen interrupt gating.
// Assumes serial pins and touch sense are asynchronous to clk (20 MHz);
// serial_bit_clock is sampled, never used as a clock.
`timescale 1ns/10ps
`default_nettype none
`include "tcwpi_params.svh"

module tcwpi_top
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 serial_bit_clock,
  input  wire logic                 serial_data_in,
  input  wire logic                 touch_sense,
  output logic                      touch_irq_n_o,
  output logic                      touch_irq_n_oe,
  output tcwpi_pkg::tcwpi_ctrl_s    ctrl_word,
  output logic                      ref_from_drivers,
  output logic                      conv_busy,
  output logic                      conv_done
);

  // ===========================================================
  // Input synchronisers
  logic [1:0] sck_sync_q;
  logic [1:0] din_sync_q;
  logic [1:0] touch_sync_q;
  logic       sck_prev_q;
  logic       sck_rise;
  logic       sck_fall;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_sync_q   <= 2'h0;
      din_sync_q   <= 2'h0;
      touch_sync_q <= 2'h0;
      sck_prev_q   <= 1'b0;
    end
    else
    begin
      sck_sync_q   <= {sck_sync_q[0], serial_bit_clock};
      din_sync_q   <= {din_sync_q[0], serial_data_in};
      touch_sync_q <= {touch_sync_q[0], touch_sense};
      sck_prev_q   <= sck_sync_q[1];
    end
  end

  assign sck_rise = sck_sync_q[1] & ~sck_prev_q;
  assign sck_fall = ~sck_sync_q[1] & sck_prev_q;

  // ===========================================================
  // Word framing
  tcwpi_pkg::tcwpi_state_e state_q;
  logic [2:0]              bit_cnt_q;
  logic [4:0]              cyc_cnt_q;
  logic [6:0]              shift_q;
  logic                    start_det;
  logic                    word_done;
  logic                    conv_end;
  logic [4:0]              conv_len;

  // Data bits are taken on rising edges, so the marker is seen there
  assign start_det = sck_rise & din_sync_q[1] &
                     (state_q != tcwpi_pkg::ST_SHIFT);
  assign word_done = sck_rise & (state_q == tcwpi_pkg::ST_SHIFT) &
                     (bit_cnt_q == 3'h6);
  // Word period counted from the marker edge
  assign conv_len  = ctrl_word.res_8bit ? `TCWPI_CYC_8BIT
                                        : `TCWPI_CYC_12BIT;
  assign conv_end  = sck_rise & (state_q == tcwpi_pkg::ST_CONV) &
                     (cyc_cnt_q == conv_len - 5'h1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= tcwpi_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        tcwpi_pkg::ST_IDLE:
          if (start_det)
            state_q <= tcwpi_pkg::ST_SHIFT;
        tcwpi_pkg::ST_SHIFT:
          if (word_done)
            state_q <= tcwpi_pkg::ST_CONV;
        tcwpi_pkg::ST_CONV:
          if (start_det)
            state_q <= tcwpi_pkg::ST_SHIFT;
          else if (conv_end)
            state_q <= tcwpi_pkg::ST_IDLE;
        default:
          state_q <= tcwpi_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_q <= 3'h0;
      cyc_cnt_q <= 5'h0;
      shift_q   <= 7'h00;
    end
    else if (start_det)
    begin
      bit_cnt_q <= 3'h0;
      cyc_cnt_q <= 5'h1;
    end
    else if (sck_rise)
    begin
      if (state_q == tcwpi_pkg::ST_SHIFT)
      begin
        shift_q   <= {shift_q[5:0], din_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (cyc_cnt_q != 5'h1F)
        cyc_cnt_q <= cyc_cnt_q + 5'h1;
    end
  end

  // ===========================================================
  // Control word register
  logic [6:0] word_next;
  assign word_next = {shift_q[5:0], din_sync_q[1]};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_word <= tcwpi_pkg::tcwpi_ctrl_s'(`TCWPI_RST_WORD);
    else if (word_done)
      ctrl_word <= tcwpi_pkg::tcwpi_ctrl_s'(word_next);
  end

  // Differential only when the bit is 0; single-ended is pin to ground
  assign ref_from_drivers = ~ctrl_word.ref_mode_sel;
  assign conv_busy = (state_q != tcwpi_pkg::ST_IDLE);
  // No dummy cycle: first word after reset converts normally
  assign conv_done = conv_end;

  // ===========================================================
  // Pen interrupt
  logic       irq_en_q;
  logic       irq_low_q;
  logic [3:0] fall_cnt_q;
  logic       pwr_allows;

  assign pwr_allows = ~(ctrl_word.pwr_mgmt_hi & ctrl_word.pwr_mgmt_lo);

  // Enable follows the loaded power bits only at conversion end;
  // also valid while idle and powered down between conversions
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_en_q <= 1'b1;
    else if (start_det)
      irq_en_q <= 1'b0;
    else if (conv_end)
      irq_en_q <= pwr_allows;
  end

  // Falls counted after a marker, held low output released on the fourth
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_low_q  <= 1'b0;
      fall_cnt_q <= 4'h0;
    end
    else if (start_det)
    begin
      irq_low_q  <= irq_low_q;
      fall_cnt_q <= 4'h0;
    end
    else if (irq_en_q)
      irq_low_q <= touch_sync_q[1];
    else if (sck_fall && irq_low_q)
    begin
      fall_cnt_q <= fall_cnt_q + 4'h1;
      if (fall_cnt_q == `TCWPI_IRQ_RELEASE_FALL - 4'h1)
        irq_low_q <= 1'b0;
    end
  end

  // Open drain: only ever drives low, released otherwise
  assign touch_irq_n_o  = 1'b0;
  assign touch_irq_n_oe = irq_low_q;

  // ===========================================================
  // Assertions
  property p_start_disables;
    @(posedge clk) disable iff (!rst_n)
      start_det |=> !irq_en_q;
  endproperty
  a_start_disables: assert property (p_start_disables)
    else $error("pen interrupt stays enabled after marker");

  property p_released_when_idle;
    @(posedge clk) disable iff (!rst_n)
      (irq_en_q && !touch_sync_q[1] && !start_det) |=> !touch_irq_n_oe;
  endproperty
  a_released_when_idle: assert property (p_released_when_idle)
    else $error("pen output driven without touch");

  property p_touch_pulls;
    @(posedge clk) disable iff (!rst_n)
      (irq_en_q && touch_sync_q[1] && !start_det) |=> touch_irq_n_oe;
  endproperty
  a_touch_pulls: assert property (p_touch_pulls)
    else $error("touch did not pull pen output low");

  property p_hold_until_fourth;
    @(posedge clk) disable iff (!rst_n)
      (!irq_en_q && irq_low_q && sck_fall && fall_cnt_q < 4'h3 &&
       !start_det) |=> irq_low_q;
  endproperty
  a_hold_until_fourth: assert property (p_hold_until_fourth)
    else $error("pen output released before fourth fall");

  property p_release_fourth;
    @(posedge clk) disable iff (!rst_n)
      (!irq_en_q && irq_low_q && sck_fall && fall_cnt_q == 4'h3 &&
       !start_det) |=> !irq_low_q && !irq_en_q;
  endproperty
  a_release_fourth: assert property (p_release_fourth)
    else $error("fourth fall mishandled");

  property p_reenable_at_end;
    @(posedge clk) disable iff (!rst_n)
      (conv_end && !start_det) |=> (irq_en_q == $past(pwr_allows));
  endproperty
  a_reenable_at_end: assert property (p_reenable_at_end)
    else $error("enable not taken from power bits");

  property p_full_power_disables;
    @(posedge clk) disable iff (!rst_n)
      (conv_end && ctrl_word.pwr_mgmt_hi && ctrl_word.pwr_mgmt_lo)
      |=> !irq_en_q;
  endproperty
  a_full_power_disables: assert property (p_full_power_disables)
    else $error("interrupt enabled at full power");

  property p_word_frame;
    @(posedge clk) disable iff (!rst_n)
      (start_det && state_q == tcwpi_pkg::ST_IDLE)
      |=> (state_q == tcwpi_pkg::ST_SHIFT) && bit_cnt_q == 3'h0;
  endproperty
  a_word_frame: assert property (p_word_frame)
    else $error("marker did not open word");

  property p_ignore_low;
    @(posedge clk) disable iff (!rst_n)
      (state_q == tcwpi_pkg::ST_IDLE && !start_det)
      |=> state_q != tcwpi_pkg::ST_SHIFT;
  endproperty
  a_ignore_low: assert property (p_ignore_low)
    else $error("word opened without marker");

  property p_ctrl_only_on_word;
    @(posedge clk) disable iff (!rst_n)
      !word_done |=> $stable(ctrl_word);
  endproperty
  a_ctrl_only_on_word: assert property (p_ctrl_only_on_word)
    else $error("control word changed outside a word load");

  property p_idle_enable_power;
    @(posedge clk) disable iff (!rst_n)
      (state_q == tcwpi_pkg::ST_IDLE && irq_en_q) |-> pwr_allows;
  endproperty
  a_idle_enable_power: assert property (p_idle_enable_power)
    else $error("interrupt enabled in idle at full power");

  c_word_loaded: cover property (@(posedge clk) disable iff (!rst_n)
    word_done);
  c_release: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(irq_low_q) && !irq_en_q);
  c_conv_end: cover property (@(posedge clk) disable iff (!rst_n)
    conv_end ##1 irq_en_q);
  c_overlap: cover property (@(posedge clk) disable iff (!rst_n)
    start_det && state_q == tcwpi_pkg::ST_CONV);

endmodule : tcwpi_top
`default_nettype wire

/* shared/tcwpi_params.svh */
// Timing counts and control word layout for the touch control word block.
// Included by the package and the design; holds definitions only.
`ifndef TCWPI_PARAMS_SVH
`define TCWPI_PARAMS_SVH

`define TCWPI_WORD_BITS        8
`define TCWPI_POS_CHAN_HI      6
`define TCWPI_POS_CHAN_LO      4
`define TCWPI_POS_RES          3
`define TCWPI_POS_REF          2
`define TCWPI_POS_PWR_HI       1
`define TCWPI_POS_PWR_LO       0
`define TCWPI_RST_PWR          2'h2
`define TCWPI_RST_WORD         7'h02
`define TCWPI_IRQ_RELEASE_FALL 4'h4
`define TCWPI_CYC_12BIT        5'h0F
`define TCWPI_CYC_8BIT         5'h0B

`endif

/* shared/tcwpi_pkg.sv */
// Types shared by the touch control word block.
// Assumes tcwpi_params.svh is on the include path.
`include "tcwpi_params.svh"

package tcwpi_pkg;

  typedef struct packed {
    logic [2:0] chan_sel;
    logic       res_8bit;
    logic       ref_mode_sel;
    logic       pwr_mgmt_hi;
    logic       pwr_mgmt_lo;
  } tcwpi_ctrl_s;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SHIFT = 4'h2,
    ST_CONV  = 4'h4,
    ST_RSVD  = 4'h8
  } tcwpi_state_e;

endpackage : tcwpi_pkg

/* sim/tcwpi_host_model.sv */
// Host model: shifts control words on the serial clock and data lines.
// Assumes the bench clock clk; one serial period is 8 clk (400 ns).
`timescale 1ns/10ps
`default_nettype none

module tcwpi_host_model
(
  input  wire logic clk,
  output var  logic serial_bit_clock,
  output var  logic serial_data_in
);
  // ==========================================================
  // Serial driver
  initial
  begin
    serial_bit_clock = 1'b0;
    serial_data_in   = 1'b0;
  end

  // Clock stands low between words; data is driven, never released
  task automatic bit_cycle(input logic b);
    serial_data_in = b;
    repeat (4) @(negedge clk);
    serial_bit_clock = 1'b1;
    repeat (4) @(negedge clk);
    serial_bit_clock = 1'b0;
  endtask : bit_cycle

  // Marker bit leads, zeros pad out the word period
  task automatic send_word(input logic [7:0] w, input int n);
    for (int i = 0; i < n; i++)
      bit_cycle(i < 8 ? w[7 - i] : 1'b0);
  endtask : send_word
endmodule : tcwpi_host_model

`default_nettype wire

/* sim/tcwpi_tb_top.sv */
// Self-checking bench of the control word and pen interrupt block.
// Assumes tcwpi_pkg and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tcwpi_tb_top;
  // ==========================================================
  // Signals
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   touch = 1'b0;
  logic                   sck;
  logic                   sdi;
  logic                   irq_o;
  logic                   irq_oe;
  logic                   ref_drv;
  logic                   busy;
  logic                   done;
  tcwpi_pkg::tcwpi_ctrl_s ctrl;
  int                     num_errors = 0;
  int                     checks_done = 0;
  int                     n_done = 0;
  int                     cycles = 0;
  logic [7:0]             seed = 8'h50;
  logic [7:0]             w;
  logic                   en_m = 1'b1;
  logic [6:0]             exp_q[$];
  // Channels that may use driver referencing; codes chosen arbitrarily
  localparam logic [7:0]  diff_chan_mask = 8'h36;
  // Open-drain pin with pull-up
  wire                    irq_pin = irq_oe ? irq_o : 1'b1;

  always #25 clk = ~clk;

  tcwpi_host_model i_host
  (
    .clk              (clk),
    .serial_bit_clock (sck),
    .serial_data_in   (sdi)
  );

  tcwpi_top i_dut
  (
    .clk              (clk),
    .rst_n            (rst_n),
    .serial_bit_clock (sck),
    .serial_data_in   (sdi),
    .touch_sense      (touch),
    .touch_irq_n_o    (irq_o),
    .touch_irq_n_oe   (irq_oe),
    .ctrl_word        (ctrl),
    .ref_from_drivers (ref_drv),
    .conv_busy        (busy),
    .conv_done        (done)
  );

  // ==========================================================
  // Checking
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // Done pulses are counted; a hang is cut off well past the run
  always @(posedge clk)
  begin
    if (done === 1'b1)
      n_done++;
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk_word(input logic [6:0] got, input logic [6:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t ctrl got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string s);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask : chk_bit

  function automatic logic [7:0] xs(input logic [7:0] s);
    s = s ^ (s << 7);
    s = s ^ (s >> 5);
    s = s ^ (s << 3);
    return s;
  endfunction : xs

  // One whole word, then the decoded fields and one end pulse
  task automatic do_word(input logic [7:0] v);
    int n0;
    n0 = n_done;
    exp_q.push_back(v[6:0]);
    i_host.send_word(v, v[3] ? 11 : 15);
    repeat (4) @(negedge clk);
    chk_word(ctrl, exp_q.pop_front());
    chk_bit(ref_drv, ~v[2], "ref");
    chk_bit(n_done - n0 == 1, 1'b1, "done");
    chk_bit(busy, 1'b0, "busy");
    en_m = ~(v[1] & v[0]);
  endtask : do_word

  task automatic touch_chk(input logic t);
    touch = t;
    repeat (8) @(negedge clk);
    chk_bit(irq_pin, ~(t & en_m), "pin");
  endtask : touch_chk

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_word(ctrl, 7'h02);
    touch_chk(1'b0);
    touch_chk(1'b1);
    $display("test reset done");
    // Touch held through a marker: low until the fourth fall only
    w = 8'h93;
    // Each look falls three clocks after the host drives a serial clock fall
    fork
      i_host.send_word(w, 15);
      for (int i = 0; i < 15; i++)
      begin
        repeat (i == 0 ? 11 : 8) @(negedge clk);
        if (i < 6)
          chk_bit(irq_pin, i >= 3, "hold");
        chk_bit(busy, i < 14, "busy");
      end
    join
    chk_word(ctrl, w[6:0]);
    en_m = 1'b0;
    touch_chk(1'b1);
    $display("test marker done");
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      w = {1'b1, seed[6:4], k[2], seed[2] | ~diff_chan_mask[seed[6:4]],
           k[1:0]};
      touch_chk(1'b0);
      repeat (k % 3) i_host.bit_cycle(1'b0);
      do_word(w);
      touch_chk(1'b1);
    end
    $display("test words done");
    // Next word overlapping the conversion keeps the interrupt off
    do_word(8'h90);
    touch_chk(1'b1);
    i_host.send_word(8'h90, 10);
    chk_bit(irq_pin, 1'b1, "ovl");
    chk_bit(busy, 1'b1, "ovl busy");
    do_word(8'h84);
    touch_chk(1'b1);
    $display("test overlap done");
    finish_test();
  end
endmodule : tcwpi_tb_top

`default_nettype wire
